// [sim/sbpc_jtag_host.sv]
// Behavioural JTAG host: system programming, password entry and loader commands
`timescale 1ns/1ps
module sbpc_jtag_host (
  input  wire logic  ref_clk_in,
  output logic       jtag_sysprog_in,
  output logic       pw_restart_in,
  output logic       pw_word_valid_in,
  output logic [15:0] pw_word_in,
  output logic       loader_cmd_valid_in,
  output logic [2:0] loader_cmd_in,
  output logic       loader_exit_in
);
  initial
  begin
    {jtag_sysprog_in, pw_restart_in, pw_word_valid_in, loader_cmd_valid_in, loader_exit_in} = 5'h00;
    pw_word_in    = 16'h0000;
    loader_cmd_in = 3'h7;
  end
  // Caller holds the level across the reset pulse
  task sysprog(input logic v);
    @(posedge ref_clk_in);
    jtag_sysprog_in <= v;
  endtask
  task pw_send(input logic [255:0] v);
    integer i;
    @(posedge ref_clk_in);
    pw_restart_in <= 1'b1;
    @(posedge ref_clk_in);
    pw_restart_in <= 1'b0;
    for (i = 0; i < 16; i = i + 1)
    begin
      pw_word_valid_in <= 1'b1;
      pw_word_in       <= v[16*i +: 16];
      @(posedge ref_clk_in);
    end
    pw_word_valid_in <= 1'b0;
    // Released data lines do not keep the last word
    pw_word_in       <= ~pw_word_in;
  endtask
  task lcmd(input logic [2:0] c);
    @(posedge ref_clk_in);
    loader_cmd_valid_in <= 1'b1;
    loader_cmd_in       <= c;
    @(posedge ref_clk_in);
    loader_cmd_valid_in <= 1'b0;
    loader_cmd_in       <= ~c;
  endtask
  task lexit;
    @(posedge ref_clk_in);
    loader_exit_in <= 1'b1;
    @(posedge ref_clk_in);
    loader_exit_in <= 1'b0;
  endtask
endmodule

// [sim/sbpc_monitor.sv]
// Checker of stack, decode, dispatch and lock behaviour at the control block ports
`timescale 1ns/1ps
module sbpc_monitor (
  input wire logic        ref_clk_in, reset_n_in, call_in, int_vector_in, push_in,
  input wire logic        subroutine_return_in, interrupt_return_in, pop_in, pop_with_interrupt_in,
  input wire logic        return_valid_out, pop_valid_out, int_reenable_out, mem_req_in, code_space_in,
  input wire logic        rom_dispatch_in, fetch_load_out, code_lock_flag_out, boot_program_enable_out,
  input wire logic        mass_erase_in, pw_unlocked_out, pw_required_out, isp_grant_out, iap_grant_out,
  input wire logic        debug_grant_out, jtag_sysprog_in, loader_exit_in, sys_reset_req_out,
  input wire logic [3:0]  stack_level_pointer_out,
  input wire logic [15:0] mem_addr_in, region_offset_out, fetch_addr_out,
  input wire logic [1:0]  region_out, rom_route_in
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);
  // Simultaneous push and pop keeps the pointer, so both kinds are excluded below
  wire pu = push_in | call_in | int_vector_in;
  wire po = subroutine_return_in | interrupt_return_in | pop_in | pop_with_interrupt_in;
  //////////////////////////////////////////////////////////////////////////////
  reset_ptr_a: assert property ($rose(reset_n_in) |-> stack_level_pointer_out == 4'hf)
    else $error("pointer not at top after reset");
  boot_fetch_a: assert property ($rose(reset_n_in) |-> fetch_load_out && fetch_addr_out == 16'h8000)
    else $error("fetch not loaded with rom base at reset");
  push_inc_a: assert property (pu && !po |=> stack_level_pointer_out == $past(stack_level_pointer_out) + 4'h1)
    else $error("pointer not incremented by push");
  pop_dec_a: assert property (po && !pu |=> stack_level_pointer_out == $past(stack_level_pointer_out) - 4'h1)
    else $error("pointer not decremented by pop");
  pop_answer_a: assert property ((pop_in || pop_with_interrupt_in) && !pu |-> ##2 pop_valid_out)
    else $error("pop answer missing");
  ret_answer_a: assert property ((subroutine_return_in || interrupt_return_in) && !pu |-> ##2 return_valid_out)
    else $error("return answer missing");
  reenable_a: assert property (interrupt_return_in || pop_with_interrupt_in |-> ##2 int_reenable_out)
    else $error("interrupt reenable missing");
  rom_decode_a: assert property (mem_req_in && code_space_in && mem_addr_in[15:11] == 5'h10 |=>
    region_out == 2'h2 && region_offset_out == ($past(mem_addr_in) & 16'h07ff))
    else $error("rom decode wrong");
  dispatch_app_a: assert property (rom_dispatch_in && rom_route_in == 2'h0 |=> fetch_load_out && fetch_addr_out == 16'h0000)
    else $error("application dispatch wrong");
  grant_gate_a: assert property (isp_grant_out || iap_grant_out || debug_grant_out |-> !pw_required_out || pw_unlocked_out)
    else $error("access granted while locked");
  no_lock_a: assert property (!code_lock_flag_out |-> !pw_required_out)
    else $error("password demanded with lock clear");
  erase_open_a: assert property (mass_erase_in |-> ##2 !pw_required_out)
    else $error("password still demanded after erase");
  spe_set_a: assert property ($rose(reset_n_in) && $past(jtag_sysprog_in) |-> boot_program_enable_out)
    else $error("boot program enable not set");
  loader_exit_a: assert property (loader_exit_in |=> sys_reset_req_out && !boot_program_enable_out)
    else $error("loader exit wrong");
endmodule

bind sbpc_ctrl sbpc_monitor i_sbpc_monitor (.*);

// [sim/tb.sv]
// Self-checking bench of the stack, boot entry and password lock control
`timescale 1ns/1ps
module tb;
  logic ref_clk_in = 0, reset_n_in = 0, por_n_in = 0, call_in = 0, int_vector_in = 0, push_in = 0;
  logic subroutine_return_in = 0, interrupt_return_in = 0, pop_in = 0, pop_with_interrupt_in = 0;
  logic mem_req_in = 0, code_space_in = 0, von_neumann_in = 0, rom_dispatch_in = 0, flash_wr_in = 0;
  logic code_lock_set_in = 0, code_lock_clear_in = 0, mass_erase_in = 0;
  logic isp_req_in = 0, iap_req_in = 0, debug_req_in = 0;
  logic [15:0] return_addr_in = 0, push_data_in = 0, mem_addr_in = 0, flash_wr_addr_in = 0, flash_wr_data_in = 0;
  logic [1:0]  rom_route_in = 0;
  wire         jtag_sysprog_in, pw_restart_in, pw_word_valid_in, loader_cmd_valid_in, loader_exit_in;
  wire [15:0]  pw_word_in, return_target_out, pop_data_out, region_offset_out, fetch_addr_out;
  wire [2:0]   loader_cmd_in, loader_cmd_out;
  wire         return_valid_out, pop_valid_out, int_reenable_out, fetch_load_out, dispatch_refused_out;
  wire         code_lock_flag_out, boot_program_enable_out, pw_unlocked_out, pw_required_out;
  wire         isp_grant_out, iap_grant_out, debug_grant_out, loader_cmd_accept_out, loader_cmd_reject_out;
  wire         flash_mass_erase_out, sys_reset_req_out;
  wire [3:0]   stack_level_pointer_out;
  wire [1:0]   region_out;
  int          i, k, mp, op, cyc = 0, n_mismatch = 0, samples_checked = 0;
  int          bs [5] = '{32'h8000, 32'h0000, 32'h0000, 32'ha000, 32'h0800};
  int          rg [5] = '{2, 1, 3, 3, 0};
  logic [15:0] ent [4] = '{16'h0000, 16'h8010, 16'h8020, 16'h8030};
  logic [15:0] mem [16];
  logic [15:0] want;
  logic [31:0] rnd = 32'hb3a5;
  logic [255:0] pw;
  logic [2:0]  c;
  logic        e;

  sbpc_ctrl i_sbpc_ctrl (.*);
  sbpc_jtag_host i_sbpc_jtag_host (.*);

  always #25 ref_clk_in = ~ref_clk_in;
  always @(posedge ref_clk_in)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_mismatch++;
      end_of_test;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  function logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task chk(input logic [31:0] seen, input logic [31:0] exp_v);
    samples_checked++;
    if (seen !== exp_v)
    begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp_v);
    end
  endtask
  task end_of_test;
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Every request task but fwr ends just after its take edge, outputs settled except the spop answers, one edge later; fwr ends one edge later
  task spush(input int kd, input logic [15:0] d);
    @(posedge ref_clk_in);
    {return_addr_in, push_data_in} <= {d, d};
    {push_in, int_vector_in, call_in} <= 3'h1 << kd;
    @(posedge ref_clk_in);
    {push_in, int_vector_in, call_in} <= 3'h0;
    {return_addr_in, push_data_in} <= ~{d, d};
    #1;
  endtask
  task spop(input int kd);
    @(posedge ref_clk_in);
    {pop_with_interrupt_in, pop_in, interrupt_return_in, subroutine_return_in} <= 4'h1 << kd;
    @(posedge ref_clk_in);
    {pop_with_interrupt_in, pop_in, interrupt_return_in, subroutine_return_in} <= 4'h0;
    #1;
  endtask
  task mreq(input logic vn, input logic cs, input logic [15:0] a);
    @(posedge ref_clk_in);
    {von_neumann_in, code_space_in, mem_addr_in, mem_req_in} <= {vn, cs, a, 1'b1};
    @(posedge ref_clk_in);
    {mem_addr_in, mem_req_in} <= {~a, 1'b0};
    #1;
  endtask
  // kd: 0 dispatch, 1 lock clear, 2 lock set, 3 mass erase
  task ctl(input int kd, input logic [1:0] r);
    @(posedge ref_clk_in);
    rom_route_in <= r;
    {mass_erase_in, code_lock_set_in, code_lock_clear_in, rom_dispatch_in} <= 4'h1 << kd;
    @(posedge ref_clk_in);
    rom_route_in <= ~r;
    {mass_erase_in, code_lock_set_in, code_lock_clear_in, rom_dispatch_in} <= 4'h0;
    #1;
  endtask
  task fwr(input logic [15:0] a, input logic [15:0] d);
    @(posedge ref_clk_in);
    {flash_wr_in, flash_wr_addr_in, flash_wr_data_in} <= {1'b1, a, d};
    @(posedge ref_clk_in);
    {flash_wr_in, flash_wr_addr_in, flash_wr_data_in} <= {1'b0, ~a, ~d};
    @(posedge ref_clk_in);
    #1;
  endtask
  task gr(input logic g);
    chk({isp_grant_out, iap_grant_out, debug_grant_out}, {3{g}});
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (7) @(posedge ref_clk_in);
    #1;
    chk({fetch_load_out, fetch_addr_out, stack_level_pointer_out}, 21'h18000f);
    @(posedge ref_clk_in);
    {reset_n_in, por_n_in} <= 2'h3;
    @(posedge ref_clk_in);
    #1;
    chk({code_lock_flag_out, boot_program_enable_out, pw_required_out, fetch_load_out}, 4'h8);
    mp = 15;
    for (i = 0; i < 17; i++)
    begin
      rnd = lfsr(rnd);
      mp = (mp + 1) % 16;
      mem[mp] = rnd[15:0];
      spush(i % 3, rnd[15:0]);
      chk(stack_level_pointer_out, mp);
    end
    for (i = 0; i < 17; i++)
    begin
      k = i % 4;
      spop(k);
      want = mem[mp];
      mp = (mp + 15) % 16;
      chk(stack_level_pointer_out, mp);
      @(posedge ref_clk_in);
      #1;
      chk(k < 2 ? {return_valid_out, return_target_out} : {pop_valid_out, pop_data_out}, {1'b1, want});
      chk(int_reenable_out, k % 2);
    end
    for (i = 0; i < 5; i++)
    begin
      rnd = lfsr(rnd);
      mreq(i == 3, i < 2, bs[i] + rnd[10:0]);
      chk(region_out, rg[i]);
      if (rg[i] != 0) chk(region_offset_out, rnd[10:0]);
    end
    ctl(0, 0);
    chk({fetch_load_out, fetch_addr_out}, 17'h10000);
    ctl(0, 1);
    chk(dispatch_refused_out, 1);
    for (i = 0; i < 16; i++)
    begin
      rnd = lfsr(rnd);
      pw[16*i +: 16] = rnd[15:0] & 16'h7fff | 16'h0001;
      fwr(16'h0010 + i, pw[16*i +: 16]);
    end
    chk(pw_required_out, 1);
    @(posedge ref_clk_in);
    {isp_req_in, iap_req_in, debug_req_in} <= 3'h7;
    ctl(0, 2);
    chk(dispatch_refused_out, 1);
    gr(0);
    i_sbpc_jtag_host.pw_send(pw ^ {1'b1, 255'h0});
    #1;
    chk(pw_unlocked_out, 0);
    i_sbpc_jtag_host.pw_send(pw);
    #1;
    chk(pw_unlocked_out, 1);
    gr(1);
    // General reset alone keeps the lock but drops the unlock
    i_sbpc_jtag_host.sysprog(1);
    reset_n_in <= 1'b0;
    repeat (2) @(posedge ref_clk_in);
    reset_n_in <= 1'b1;
    i_sbpc_jtag_host.sysprog(0);
    #1;
    chk({boot_program_enable_out, code_lock_flag_out, pw_unlocked_out, pw_required_out}, 4'hd);
    gr(0);
    ctl(1, 0);
    chk({code_lock_flag_out, pw_required_out}, 2'h0);
    gr(1);
    ctl(2, 0);
    chk(pw_required_out, 1);
    ctl(3, 0);
    @(posedge ref_clk_in);
    #1;
    chk(pw_required_out, 0);
    fwr(16'h0010, 16'h1234);
    chk(pw_required_out, 1);
    op = 0;
    for (i = 0; i < 12; i++)
    begin
      c = i % 6;
      e = c == 4 || (c < 4 && op);
      i_sbpc_jtag_host.lcmd(c);
      #1;
      chk({loader_cmd_accept_out, loader_cmd_reject_out, flash_mass_erase_out}, {e, !e, c == 3'h4});
      if (e) chk(loader_cmd_out, c);
      if (c == 4) op = 1;
    end
    for (i = 0; i < 4; i++)
    begin
      ctl(0, i);
      chk({fetch_load_out, fetch_addr_out}, {1'b1, ent[i]});
    end
    i_sbpc_jtag_host.lexit;
    #1;
    chk({sys_reset_req_out, boot_program_enable_out}, 2'h2);
    ctl(0, 1);
    chk(dispatch_refused_out, 1);
    end_of_test;
  end
endmodule

// [verilog/sbpc_ctrl.v]
// Stack, memory map, boot entry, password lock and loader entry control
`timescale 1ns/1ps
`include "sbpc_defines.vh"
module sbpc_ctrl #(
  parameter WIDTH = `SBPC_STACK_WIDTH,
  parameter DEPTH = `SBPC_STACK_DEPTH
) (
  input  wire             ref_clk_in,
  input  wire             reset_n_in,
  input  wire             por_n_in,
  input  wire             call_in,
  input  wire             int_vector_in,
  input  wire [15:0]      return_addr_in,
  input  wire             push_in,
  input  wire [15:0]      push_data_in,
  input  wire             subroutine_return_in,
  input  wire             interrupt_return_in,
  input  wire             pop_in,
  input  wire             pop_with_interrupt_in,
  output reg  [15:0]      return_target_out,
  output reg              return_valid_out,
  output reg  [15:0]      pop_data_out,
  output reg              pop_valid_out,
  output reg              int_reenable_out,
  output wire [3:0]       stack_level_pointer_out,
  input  wire             mem_req_in,
  input  wire             code_space_in,
  input  wire [15:0]      mem_addr_in,
  input  wire             von_neumann_in,
  output reg  [1:0]       region_out,
  output reg  [15:0]      region_offset_out,
  input  wire             rom_dispatch_in,
  input  wire [1:0]       rom_route_in,
  output reg  [15:0]      fetch_addr_out,
  output reg              fetch_load_out,
  output reg              dispatch_refused_out,
  input  wire             code_lock_set_in,
  input  wire             code_lock_clear_in,
  output reg              code_lock_flag_out,
  output reg              boot_program_enable_out,
  input  wire             flash_wr_in,
  input  wire [15:0]      flash_wr_addr_in,
  input  wire [15:0]      flash_wr_data_in,
  input  wire             mass_erase_in,
  input  wire             pw_restart_in,
  input  wire             pw_word_valid_in,
  input  wire [15:0]      pw_word_in,
  output reg              pw_unlocked_out,
  output wire             pw_required_out,
  input  wire             isp_req_in,
  input  wire             iap_req_in,
  input  wire             debug_req_in,
  output wire             isp_grant_out,
  output wire             iap_grant_out,
  output wire             debug_grant_out,
  input  wire             jtag_sysprog_in,
  input  wire             loader_cmd_valid_in,
  input  wire [2:0]       loader_cmd_in,
  input  wire             loader_exit_in,
  output reg              loader_cmd_accept_out,
  output reg              loader_cmd_reject_out,
  output reg  [2:0]       loader_cmd_out,
  output reg              flash_mass_erase_out,
  output reg              sys_reset_req_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Stack

  wire             stk_push;
  wire             stk_pop;
  wire [WIDTH-1:0] stk_push_data;
  wire [WIDTH-1:0] stk_pop_data;
  wire             stk_pop_valid;
  reg              pop_was_return;
  reg              pop_was_interrupt_return;
  reg              pop_was_pop_with_interrupt;

  // Return address for call and vectoring, explicit value for push
  assign stk_push      = call_in | int_vector_in | push_in;
  assign stk_pop       = subroutine_return_in | interrupt_return_in | pop_in | pop_with_interrupt_in;
  assign stk_push_data = push_in ? push_data_in : return_addr_in;

  sbpc_stack #(
    .DEPTH (DEPTH),
    .WIDTH (WIDTH),
    .PTR_W (`SBPC_PTR_WIDTH)
  ) u_stack (
    .ref_clk_in    (ref_clk_in),
    .reset_n_in    (reset_n_in),
    .push_in       (stk_push),
    .push_data_in  (stk_push_data),
    .pop_in        (stk_pop),
    .pop_data_out  (stk_pop_data),
    .pop_valid_out (stk_pop_valid),
    .level_ptr_out (stack_level_pointer_out)
  );

  always @(posedge ref_clk_in)
  begin
    if (!reset_n_in)
    begin
      pop_was_return    <= 1'b0;
      pop_was_interrupt_return      <= 1'b0;
      pop_was_pop_with_interrupt      <= 1'b0;
      return_target_out <= `SBPC_APP_ORIGIN;
      return_valid_out  <= 1'b0;
      pop_data_out      <= `SBPC_WORD_ZERO;
      pop_valid_out     <= 1'b0;
      int_reenable_out  <= 1'b0;
    end
    else
    begin
      pop_was_return   <= subroutine_return_in | interrupt_return_in;
      pop_was_interrupt_return     <= interrupt_return_in;
      pop_was_pop_with_interrupt     <= pop_with_interrupt_in;
      return_valid_out <= stk_pop_valid & pop_was_return;
      pop_valid_out    <= stk_pop_valid & ~pop_was_return;
      int_reenable_out <= stk_pop_valid & (pop_was_interrupt_return | pop_was_pop_with_interrupt);
      if (stk_pop_valid && pop_was_return)
        return_target_out <= stk_pop_data;
      if (stk_pop_valid && !pop_was_return)
        pop_data_out <= stk_pop_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Memory map decode

  function in_range;
    input [15:0] addr;
    input [15:0] base;
    input [15:0] words;
    begin
      in_range = (addr >= base) && ({1'b0, addr} < ({1'b0, base} + {1'b0, words}));
    end
  endfunction

  reg [1:0]  next_region;
  reg [15:0] next_offset;

  always @*
  begin
    next_region = `SBPC_REG_NONE;
    next_offset = `SBPC_WORD_ZERO;
    if (von_neumann_in || code_space_in)
    begin
      // Program space and the contiguous map place flash and ROM alike
      if (mem_addr_in <= `SBPC_FLASH_LAST)
      begin
        next_region = `SBPC_REG_FLASH;
        next_offset = mem_addr_in;
      end
      else if (in_range(mem_addr_in, `SBPC_ROM_BASE, `SBPC_ROM_WORDS))
      begin
        next_region = `SBPC_REG_ROM;
        next_offset = mem_addr_in - `SBPC_ROM_BASE;
      end
      else if (von_neumann_in && in_range(mem_addr_in, `SBPC_VN_SRAM_BASE, `SBPC_SRAM_WORDS))
      begin
        next_region = `SBPC_REG_SRAM;
        next_offset = mem_addr_in - `SBPC_VN_SRAM_BASE;
      end
    end
    else if (in_range(mem_addr_in, `SBPC_APP_ORIGIN, `SBPC_SRAM_WORDS))
    begin
      next_region = `SBPC_REG_SRAM;
      next_offset = mem_addr_in;
    end
  end

  always @(posedge ref_clk_in)
  begin
    region_out        <= (reset_n_in && mem_req_in) ? next_region : `SBPC_REG_NONE;
    region_offset_out <= (reset_n_in && mem_req_in) ? next_offset : `SBPC_WORD_ZERO;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Password area copy and lock

  reg  [15:0] pw_area [0:`SBPC_PW_WORDS-1];
  wire [`SBPC_PW_WORDS-1:0] word_ones;
  wire [`SBPC_PW_WORDS-1:0] word_zero;
  wire        pw_write;
  wire        area_blank;
  wire        access_ok;
  reg  [3:0]  pw_idx;
  reg         pw_mismatch;
  wire        erase_cmd;

  assign pw_write = flash_wr_in && (flash_wr_addr_in >= `SBPC_PW_FIRST)
                    && (flash_wr_addr_in <= `SBPC_PW_LAST);

  genvar gi;
  generate
    for (gi = 0; gi < `SBPC_PW_WORDS; gi = gi + 1)
    begin : g_pw
      assign word_ones[gi] = (pw_area[gi] == `SBPC_WORD_ONES);
      assign word_zero[gi] = (pw_area[gi] == `SBPC_WORD_ZERO);
      always @(posedge ref_clk_in)
      begin
        // Erased area reads all ones; erase wins over a word write
        if (!por_n_in || mass_erase_in || erase_cmd)
          pw_area[gi] <= `SBPC_WORD_ONES;
        else if (pw_write && (flash_wr_addr_in[3:0] == gi[3:0]))
          pw_area[gi] <= flash_wr_data_in;
      end
    end
  endgenerate

  assign area_blank      = (&word_ones) | (&word_zero);
  assign pw_required_out = code_lock_flag_out & ~area_blank;
  assign access_ok       = ~pw_required_out | pw_unlocked_out;
  assign isp_grant_out   = isp_req_in & access_ok;
  assign iap_grant_out   = iap_req_in & access_ok;
  assign debug_grant_out = debug_req_in & access_ok;

  // Lock survives general reset; power-on or a lock set forces it back on
  always @(posedge ref_clk_in)
  begin
    if (!por_n_in)
      code_lock_flag_out <= 1'b1;
    else if (code_lock_set_in)
      code_lock_flag_out <= 1'b1;
    else if (code_lock_clear_in)
      code_lock_flag_out <= 1'b0;
  end

  // Sixteen words compared in address order
  always @(posedge ref_clk_in)
  begin
    if (!reset_n_in || pw_restart_in)
    begin
      pw_idx          <= 4'h0;
      pw_mismatch     <= 1'b0;
      pw_unlocked_out <= 1'b0;
    end
    else if (pw_word_valid_in)
    begin
      pw_idx <= pw_idx + 4'h1;
      if (pw_idx == `SBPC_PW_IDX_LAST)
      begin
        pw_unlocked_out <= ~pw_mismatch & (pw_word_in == pw_area[pw_idx]);
        pw_mismatch     <= 1'b0;
      end
      else if (pw_word_in != pw_area[pw_idx])
        pw_mismatch <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Boot program enable and reset entry

  // Captured while reset is held so the host request outlives the reset
  always @(posedge ref_clk_in)
  begin
    if (!reset_n_in && jtag_sysprog_in)
      boot_program_enable_out <= 1'b1;
    else if (!por_n_in)
      boot_program_enable_out <= 1'b0;
    else if (reset_n_in && loader_exit_in)
      boot_program_enable_out <= 1'b0;
  end

  // Loader route needs the host request, debug route needs open access
  wire dispatch_block;
  assign dispatch_block = ((rom_route_in == `SBPC_ROUTE_LOADER) && !boot_program_enable_out)
                          || ((rom_route_in == `SBPC_ROUTE_DEBUG) && !access_ok);

  always @(posedge ref_clk_in)
  begin
    if (!reset_n_in)
    begin
      fetch_addr_out       <= `SBPC_ROM_BASE;
      fetch_load_out       <= 1'b1;
      dispatch_refused_out <= 1'b0;
      sys_reset_req_out    <= 1'b0;
    end
    else
    begin
      fetch_load_out       <= 1'b0;
      dispatch_refused_out <= 1'b0;
      sys_reset_req_out    <= loader_exit_in;
      // A refused route leaves the last fetch address standing
      if (rom_dispatch_in && dispatch_block)
        dispatch_refused_out <= 1'b1;
      else if (rom_dispatch_in)
      begin
        fetch_load_out <= 1'b1;
        case (rom_route_in)
          `SBPC_ROUTE_APP:    fetch_addr_out <= `SBPC_APP_ORIGIN;
          `SBPC_ROUTE_LOADER: fetch_addr_out <= `SBPC_LOADER_ENTRY;
          `SBPC_ROUTE_DEBUG:  fetch_addr_out <= `SBPC_DEBUG_ENTRY;
          default:            fetch_addr_out <= `SBPC_TEST_ENTRY;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Loader commands

  wire cmd_known;
  assign cmd_known = (loader_cmd_in == `SBPC_CMD_LOAD) || (loader_cmd_in == `SBPC_CMD_DUMP)
                     || (loader_cmd_in == `SBPC_CMD_CRC) || (loader_cmd_in == `SBPC_CMD_VERIFY)
                     || (loader_cmd_in == `SBPC_CMD_ERASE);

  // Erase needs no password: it wipes the password together with the code
  assign erase_cmd = loader_cmd_valid_in && reset_n_in && boot_program_enable_out
                     && (loader_cmd_in == `SBPC_CMD_ERASE);

  always @(posedge ref_clk_in)
  begin
    if (!reset_n_in)
    begin
      loader_cmd_accept_out <= 1'b0;
      loader_cmd_reject_out <= 1'b0;
      loader_cmd_out        <= `SBPC_CMD_LOAD;
      flash_mass_erase_out  <= 1'b0;
    end
    else
    begin
      loader_cmd_accept_out <= 1'b0;
      loader_cmd_reject_out <= 1'b0;
      flash_mass_erase_out  <= erase_cmd;
      if (loader_cmd_valid_in)
      begin
        loader_cmd_out <= loader_cmd_in;
        if (boot_program_enable_out && cmd_known && (erase_cmd || access_ok))
          loader_cmd_accept_out <= 1'b1;
        else
          loader_cmd_reject_out <= 1'b1;
      end
    end
  end

endmodule

// [verilog/sbpc_defines.vh]
// Constants for the stack, boot entry and password lock block
`ifndef SBPC_DEFINES_VH
`define SBPC_DEFINES_VH

// Stack geometry and pointer reset value
`define SBPC_STACK_DEPTH   16
`define SBPC_STACK_WIDTH   16
`define SBPC_PTR_WIDTH     4
`define SBPC_SP_RESET      4'hf

// Word address map
`define SBPC_APP_ORIGIN    16'h0000
`define SBPC_FLASH_LAST    16'h7fff
`define SBPC_ROM_BASE      16'h8000
`define SBPC_ROM_WORDS     16'h0800
`define SBPC_SRAM_WORDS    16'h0800
`define SBPC_VN_SRAM_BASE  16'ha000

// Utility ROM routine entry points
`define SBPC_LOADER_ENTRY  16'h8010
`define SBPC_DEBUG_ENTRY   16'h8020
`define SBPC_TEST_ENTRY    16'h8030

// Password area
`define SBPC_PW_FIRST      16'h0010
`define SBPC_PW_LAST       16'h001f
`define SBPC_PW_WORDS      16
`define SBPC_PW_IDX_LAST   4'hf
`define SBPC_WORD_ONES     16'hffff
`define SBPC_WORD_ZERO     16'h0000

// Dispatch routes chosen by ROM code
`define SBPC_ROUTE_APP     2'h0
`define SBPC_ROUTE_LOADER  2'h1
`define SBPC_ROUTE_DEBUG   2'h2
`define SBPC_ROUTE_TEST    2'h3

// Loader commands
`define SBPC_CMD_LOAD      3'h0
`define SBPC_CMD_DUMP      3'h1
`define SBPC_CMD_CRC       3'h2
`define SBPC_CMD_VERIFY    3'h3
`define SBPC_CMD_ERASE     3'h4

// Region codes
`define SBPC_REG_NONE      2'h0
`define SBPC_REG_FLASH     2'h1
`define SBPC_REG_ROM       2'h2
`define SBPC_REG_SRAM      2'h3

`endif

// [verilog/sbpc_stack.v]
// Hardware return-address stack with wrapping level pointer
`timescale 1ns/1ps
`include "sbpc_defines.vh"
module sbpc_stack #(
  parameter DEPTH = `SBPC_STACK_DEPTH,
  parameter WIDTH = `SBPC_STACK_WIDTH,
  parameter PTR_W = `SBPC_PTR_WIDTH
) (
  input  wire             ref_clk_in,
  input  wire             reset_n_in,
  input  wire             push_in,
  input  wire [WIDTH-1:0] push_data_in,
  input  wire             pop_in,
  output reg  [WIDTH-1:0] pop_data_out,
  output reg              pop_valid_out,
  output reg  [PTR_W-1:0] level_ptr_out
);

  reg [WIDTH-1:0] entry [0:DEPTH-1];
  wire [PTR_W-1:0] ptr_up;
  wire [PTR_W-1:0] ptr_down;

  // Natural wrap of the narrow pointer, no error raised
  assign ptr_up   = level_ptr_out + {{(PTR_W-1){1'b0}}, 1'b1};
  assign ptr_down = level_ptr_out - {{(PTR_W-1){1'b0}}, 1'b1};

  always @(posedge ref_clk_in)
  begin
    if (!reset_n_in)
    begin
      level_ptr_out <= `SBPC_SP_RESET;
      pop_valid_out <= 1'b0;
      pop_data_out  <= {WIDTH{1'b0}};
    end
    else
    begin
      pop_valid_out <= pop_in;
      if (push_in && pop_in)
      begin
        // Both at once: top entry is returned and replaced, level unchanged
        pop_data_out               <= entry[level_ptr_out];
        entry[level_ptr_out]       <= push_data_in;
      end
      else if (push_in)
      begin
        level_ptr_out <= ptr_up;
        entry[ptr_up] <= push_data_in;
      end
      else if (pop_in)
      begin
        pop_data_out  <= entry[level_ptr_out];
        level_ptr_out <= ptr_down;
      end
    end
  end

endmodule
